// >>> pkg/arb_consts.vh
// Constants for the converter result buffer block
//
// Operation
// [RULE1] One to eight buffers, limit field is last
// [RULE2] Buffer only channels at or above start
// [RULE3] Skipped channels never produce a buffer entry
// [RULE4] Pointer at limit sets limit-reached flag
// [RULE5] Limit request only while its enable set
// [RULE6] Flag cleared by zero, DMA, low-byte write
// [RULE7] Low-byte write loads pointer, clears limit flag
// [RULE8] Software must not restart while buffering
// [RULE9] DMA emptying buffers must use burst transfers
// [RULE10] Store at pointer, then advance pointer
// [RULE11] Wrap mode returns pointer to zero
// [RULE12] Pointer above limit rolls through seven first
// [RULE13] No wrap: stop at limit, keep entries
// [RULE14] Low-byte write resumes buffering at once
// [RULE15] Conversions and result register continue while stopped
// [RULE16] Flag set plus protection: withhold, set pause
// [RULE17] Limit never triggers the protection pause
// [RULE18] Both enabled requests share one interrupt
// [RULE19] Protection off: result register always updated
// [RULE20] Every result register load sets flag
// [RULE21] Writing zero clears end flag; one ignored
// [RULE22] Protection active only with end enable set
// [RULE23] Clearing flag in pause loads withheld result
// [RULE24] Pause bit cleared only by software zero
// [RULE25] DMA completion clears limit-reached flag
// [RULE26] Buffers hold full result, always readable
`ifndef ARB_CONSTS_VH
`define ARB_CONSTS_VH

`define ARB_RES_W    10
`define ARB_CH_W     5
`define ARB_PTR_W    3
`define ARB_DEPTH    8
`define ARB_PTR_ZERO 3'h0
`define ARB_PTR_RST  3'h0
`define ARB_LIM_RST  3'h7
`define ARB_RES_RST  10'h000

`endif

// >>> verilog/arb_store.v
// Eight-entry result buffer array with one write and one read port
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.vh"

module arb_store (
    input  wire                   ref_clk,
    input  wire                   reset,
    input  wire                   wr_en,
    input  wire [`ARB_PTR_W-1:0]  wr_idx,
    input  wire [`ARB_RES_W-1:0]  wr_data,
    input  wire [`ARB_PTR_W-1:0]  rd_idx,
    output reg  [`ARB_RES_W-1:0]  rd_data_q
);

    reg [`ARB_RES_W-1:0] mem [0:`ARB_DEPTH-1];
    integer              i;

    ////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (reset) begin
            for (i = 0; i < `ARB_DEPTH; i = i + 1) begin
                mem[i] <= `ARB_RES_RST;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data; // [RULE10]
        end
    end

    // Read any time; shows the word as it stood before this edge
    always @(posedge ref_clk) begin
        if (reset) begin
            rd_data_q <= `ARB_RES_RST;
        end else begin
            rd_data_q <= mem[rd_idx]; // [RULE26]
        end
    end

endmodule // arb_store

`default_nettype wire

// >>> verilog/arb_core.v
// Converter result buffering, result protection and shared interrupt
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.vh"

module arb_core (
    input  wire                   ref_clk,
    input  wire                   reset,
    input  wire                   conv_done,
    input  wire                   conv_skipped,
    input  wire [`ARB_CH_W-1:0]   conv_channel,
    input  wire [`ARB_RES_W-1:0]  conv_result,
    input  wire [`ARB_PTR_W-1:0]  buffer_limit_level,
    input  wire [`ARB_CH_W-1:0]   buffer_start_channel,
    input  wire                   wrap_enable,
    input  wire                   limit_reached_irq_enable,
    input  wire                   end_of_conversion_irq_enable,
    input  wire                   ctrl_low_wr,
    input  wire [`ARB_PTR_W-1:0]  ctrl_low_wdata,
    input  wire                   limit_flag_wr0,
    input  wire                   eoc_flag_wr0,
    input  wire                   pause_wr0,
    input  wire                   dma_done,
    input  wire [`ARB_PTR_W-1:0]  buf_rd_idx,
    output wire [`ARB_RES_W-1:0]  buf_rd_data_q,
    output reg  [`ARB_RES_W-1:0]  result_register_q,
    output reg                    eoc_flag_q,
    output reg                    protection_pause_bit_q,
    output reg                    limit_reached_flag_q,
    output reg  [`ARB_PTR_W-1:0]  current_buffer_pointer_q,
    output reg                    buffering_active_q,
    output reg                    conv_hold_q,
    output reg                    irq_q
);

    ////////////////////////////////////////////////////////////////
    // Local state

    reg  [`ARB_RES_W-1:0]  held_result_q;
    reg  [`ARB_RES_W-1:0]  result_register_d;
    reg  [`ARB_RES_W-1:0]  held_result_d;
    reg                    eoc_flag_d;
    reg                    protection_pause_bit_d;
    reg                    limit_reached_flag_d;
    reg  [`ARB_PTR_W-1:0]  current_buffer_pointer_d;
    reg                    buffering_active_d;
    reg                    conv_hold_d;
    reg                    irq_d;

    wire                   protect_on;
    wire                   eoc_clear;
    wire                   limit_clear;
    wire                   channel_ok;
    wire                   buf_store;
    wire                   at_limit;
    wire                   withhold;
    wire                   release_held;
    wire                   load_direct;
    wire                   result_load;

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Plain 3-bit increment rolls 7 to 0 on its own
    function [`ARB_PTR_W-1:0] ptr_inc;
        input [`ARB_PTR_W-1:0] p;
        begin
            ptr_inc = p + 3'h1; // [RULE12]
        end
    endfunction

    function ptr_hits_limit;
        input [`ARB_PTR_W-1:0] p;
        input [`ARB_PTR_W-1:0] lim;
        begin
            ptr_hits_limit = (p == lim);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Protection decisions

    // Protection only exists while the end-of-conversion enable is set
    assign protect_on = end_of_conversion_irq_enable; // [RULE22]

    // DMA completion counts as retrieval of the result as well
    assign eoc_clear = eoc_flag_wr0 | dma_done; // [RULE21]

    assign limit_clear = limit_flag_wr0 | dma_done | ctrl_low_wr; // [RULE6] [RULE25] [RULE7]

    // Withhold only if the old result is still unread this cycle
    assign withhold = conv_done & eoc_flag_q & protect_on & ~eoc_clear; // [RULE16]

    // Dropping the enable in a pause also releases the held word
    assign release_held = conv_hold_q & (eoc_clear | ~protect_on); // [RULE23]

    assign load_direct = conv_done & ~withhold; // [RULE19]

    assign result_load = load_direct | release_held;

    ////////////////////////////////////////////////////////////////
    // Buffer decisions

    assign channel_ok = (conv_channel >= buffer_start_channel); // [RULE2]

    // Buffer stores withheld results too; the pause never blocks a store
    assign buf_store = conv_done & ~conv_skipped & channel_ok & buffering_active_q; // [RULE3] [RULE17]

    assign at_limit = ptr_hits_limit(current_buffer_pointer_q, buffer_limit_level); // [RULE1]

    ////////////////////////////////////////////////////////////////
    // Result register and held word

    always @* begin
        result_register_d = result_register_q;
        held_result_d     = held_result_q;
        if (release_held) begin
            result_register_d = held_result_q; // [RULE23]
        end else if (load_direct) begin
            result_register_d = conv_result; // [RULE15]
        end
        if (withhold) begin
            held_result_d = conv_result; // [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////
    // End-of-conversion flag, pause bit, converter hold

    always @* begin
        eoc_flag_d = eoc_flag_q;
        if (eoc_clear) begin
            eoc_flag_d = 1'b0; // [RULE21]
        end
        // A new load wins over a clear in the same cycle
        if (result_load) begin
            eoc_flag_d = 1'b1; // [RULE20]
        end
    end

    always @* begin
        protection_pause_bit_d = protection_pause_bit_q;
        if (pause_wr0) begin
            protection_pause_bit_d = 1'b0; // [RULE24]
        end
        if (withhold) begin
            protection_pause_bit_d = 1'b1; // [RULE16]
        end
    end

    // Hold stalls the converter; pause bit stays for software
    always @* begin
        conv_hold_d = conv_hold_q;
        if (release_held) begin
            conv_hold_d = 1'b0; // [RULE24]
        end
        if (withhold) begin
            conv_hold_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pointer, stop state and limit flag

    always @* begin
        current_buffer_pointer_d = current_buffer_pointer_q;
        buffering_active_d       = buffering_active_q;
        if (buf_store) begin
            if (at_limit) begin
                if (wrap_enable) begin
                    current_buffer_pointer_d = `ARB_PTR_ZERO; // [RULE11]
                end else begin
                    buffering_active_d = 1'b0; // [RULE13]
                end
            end else begin
                current_buffer_pointer_d = ptr_inc(current_buffer_pointer_q); // [RULE10]
            end
        end
        // Software load of the pointer overrides the advance
        if (ctrl_low_wr) begin
            current_buffer_pointer_d = ctrl_low_wdata; // [RULE7]
            buffering_active_d       = 1'b1; // [RULE14]
        end
    end

    always @* begin
        limit_reached_flag_d = limit_reached_flag_q;
        if (limit_clear) begin
            limit_reached_flag_d = 1'b0; // [RULE6]
        end
        if (buf_store & at_limit) begin
            limit_reached_flag_d = 1'b1; // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////
    // Shared interrupt, follows next flag values

    always @* begin
        irq_d = (eoc_flag_d & end_of_conversion_irq_enable)
              | (limit_reached_flag_d & limit_reached_irq_enable); // [RULE5] [RULE18]
    end

    ////////////////////////////////////////////////////////////////
    // Registers

    always @(posedge ref_clk) begin
        if (reset) begin
            result_register_q <= `ARB_RES_RST;
            held_result_q     <= `ARB_RES_RST;
        end else begin
            result_register_q <= result_register_d;
            held_result_q     <= held_result_d;
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            eoc_flag_q             <= 1'b0;
            protection_pause_bit_q <= 1'b0;
            conv_hold_q            <= 1'b0;
        end else begin
            eoc_flag_q             <= eoc_flag_d;
            protection_pause_bit_q <= protection_pause_bit_d;
            conv_hold_q            <= conv_hold_d;
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            current_buffer_pointer_q <= `ARB_PTR_RST;
            buffering_active_q       <= 1'b1;
            limit_reached_flag_q     <= 1'b0;
            irq_q                    <= 1'b0;
        end else begin
            current_buffer_pointer_q <= current_buffer_pointer_d;
            buffering_active_q       <= buffering_active_d;
            limit_reached_flag_q     <= limit_reached_flag_d;
            irq_q                    <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Buffer array; restart and DMA burst are left to software

    arb_store u_store (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .wr_en     (buf_store),
        .wr_idx    (current_buffer_pointer_q),
        .wr_data   (conv_result),
        .rd_idx    (buf_rd_idx),
        .rd_data_q (buf_rd_data_q)
    ); // [RULE26]

endmodule // arb_core

`default_nettype wire

// >>> tb/arb_core_assertions.sv
// Concurrent checks on the result buffer core ports
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.vh"
module arb_core_assertions (
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  conv_done,
    input wire logic                  conv_skipped,
    input wire logic [`ARB_CH_W-1:0]  conv_channel,
    input wire logic [`ARB_RES_W-1:0] conv_result,
    input wire logic [`ARB_PTR_W-1:0] buffer_limit_level,
    input wire logic [`ARB_CH_W-1:0]  buffer_start_channel,
    input wire logic                  wrap_enable,
    input wire logic                  limit_reached_irq_enable,
    input wire logic                  end_of_conversion_irq_enable,
    input wire logic                  ctrl_low_wr,
    input wire logic [`ARB_PTR_W-1:0] ctrl_low_wdata,
    input wire logic                  limit_flag_wr0,
    input wire logic                  eoc_flag_wr0,
    input wire logic                  pause_wr0,
    input wire logic                  dma_done,
    input wire logic [`ARB_RES_W-1:0] result_register_q,
    input wire logic                  eoc_flag_q,
    input wire logic                  protection_pause_bit_q,
    input wire logic                  limit_reached_flag_q,
    input wire logic [`ARB_PTR_W-1:0] current_buffer_pointer_q,
    input wire logic                  buffering_active_q,
    input wire logic                  irq_q
);
    // Store accepted this cycle, pointer write excluded since it wins
    wire store_ok = conv_done && !conv_skipped && conv_channel >= buffer_start_channel
                    && buffering_active_q && !ctrl_low_wr;
    wire prot = eoc_flag_q && end_of_conversion_irq_enable;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    property p_eoc_set;
        conv_done && !prot |=> eoc_flag_q && result_register_q == $past(conv_result);
    endproperty
    a_eoc_set: assert property (p_eoc_set) else $error("result load missed");
    // A clear in the same cycle counts as retrieval, so no pause then
    property p_protect;
        conv_done && prot && !eoc_flag_wr0 && !dma_done
        |=> protection_pause_bit_q && $stable(result_register_q);
    endproperty
    a_protect: assert property (p_protect) else $error("result not withheld");
    property p_pause_cause;
        $rose(protection_pause_bit_q) |-> $past(conv_done && prot);
    endproperty
    a_pause_cause: assert property (p_pause_cause) else $error("stray pause");
    property p_pause_hold;
        protection_pause_bit_q && !pause_wr0 |=> protection_pause_bit_q;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause self cleared");
    property p_advance;
        store_ok && current_buffer_pointer_q != buffer_limit_level
        |=> current_buffer_pointer_q == $past(current_buffer_pointer_q) + 3'h1;
    endproperty
    a_advance: assert property (p_advance) else $error("pointer advance wrong");
    property p_at_limit;
        store_ok && current_buffer_pointer_q == buffer_limit_level |=> limit_reached_flag_q
        && ($past(wrap_enable) ? current_buffer_pointer_q == 3'h0
        : (!buffering_active_q && $stable(current_buffer_pointer_q)));
    endproperty
    a_at_limit: assert property (p_at_limit) else $error("limit handling wrong");
    property p_no_store;
        conv_done && !store_ok && !ctrl_low_wr |=> $stable(current_buffer_pointer_q);
    endproperty
    a_no_store: assert property (p_no_store) else $error("pointer moved");
    property p_ctrl;
        ctrl_low_wr && !conv_done |=> current_buffer_pointer_q == $past(ctrl_low_wdata)
        && !limit_reached_flag_q && buffering_active_q;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("pointer write wrong");
    property p_dma;
        dma_done && !conv_done |=> !limit_reached_flag_q;
    endproperty
    a_dma: assert property (p_dma) else $error("dma clear missed");
    property p_irq_off;
        !$past(limit_reached_irq_enable) && !$past(end_of_conversion_irq_enable) |-> !irq_q;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    c_wrap: cover property (store_ok && wrap_enable && current_buffer_pointer_q == buffer_limit_level);
    c_pause: cover property ($rose(protection_pause_bit_q));
    c_irq: cover property ($rose(irq_q));
endmodule // arb_core_assertions
`default_nettype wire

// >>> tb/arb_dma_model.sv
// DMA side model: burst read of all buffers, then completion pulse
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.vh"
module arb_dma_model (
    input wire logic                     ref_clk,
    input wire logic                     start,
    input wire logic [`ARB_RES_W-1:0]    rd_data,
    output logic [`ARB_PTR_W-1:0]        rd_idx,
    output logic                         done,
    output logic [8*`ARB_RES_W-1:0]      words
);
    integer i;
    initial begin
        rd_idx = 3'h0;
        done = 1'b0;
        words = '0;
        forever begin
            @(posedge ref_clk);
            if (start) begin
                // Whole buffer in one sequence, mapping kept intact
                for (i = 0; i < 8; i = i + 1) begin
                    rd_idx <= i[2:0];
                    // Registered read port: two edges per word
                    @(posedge ref_clk);
                    @(posedge ref_clk);
                    words[i*`ARB_RES_W +: `ARB_RES_W] = rd_data;
                end
                done <= 1'b1;
                @(posedge ref_clk);
                done <= 1'b0;
            end
        end
    end
endmodule // arb_dma_model
`default_nettype wire

// >>> tb/arb_core_tb.sv
// Self-checking bench for the result buffer core
`timescale 1ns/1ps
`default_nettype none
`include "arb_consts.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module arb_core_tb;
    logic ref_clk = 0, reset = 1, conv_done = 0, conv_skipped = 0, wrap_enable = 0;
    logic limit_reached_irq_enable = 0, end_of_conversion_irq_enable = 0, dma_go = 0;
    logic ctrl_low_wr = 0, limit_flag_wr0 = 0, eoc_flag_wr0 = 0, pause_wr0 = 0;
    logic [`ARB_CH_W-1:0]  conv_channel = 0, buffer_start_channel = 0;
    logic [`ARB_RES_W-1:0] conv_result = 0;
    logic [`ARB_PTR_W-1:0] buffer_limit_level = 0, ctrl_low_wdata = 0;
    wire [`ARB_PTR_W-1:0]  buf_rd_idx, current_buffer_pointer_q;
    wire [`ARB_RES_W-1:0]  buf_rd_data_q, result_register_q;
    wire [79:0]            words;
    wire dma_done, eoc_flag_q, protection_pause_bit_q, limit_reached_flag_q;
    wire buffering_active_q, conv_hold_q, irq_q;
    int fail_count = 0, comparisons = 0, i;
    always #10 ref_clk = ~ref_clk;
    arb_core DUT (.*);
    arb_dma_model dma (.ref_clk(ref_clk), .start(dma_go), .rd_data(buf_rd_data_q),
        .rd_idx(buf_rd_idx), .done(dma_done), .words(words));
    ////////////////////////////////////////////////////////////////////////
    // One result at a time; t_stop calls ctrl while buffering is still active
    task conv(input [4:0] ch, input [9:0] res, input sk);
        {conv_done, conv_channel, conv_result, conv_skipped} = {1'b1, ch, res, sk};
        @(negedge ref_clk);
        conv_done = 0;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge ref_clk);
        s = 0;
    endtask
    task ctrl(input [2:0] p);
        ctrl_low_wdata = p;
        pulse(ctrl_low_wr);
    endtask
    task burst;
        pulse(dma_go);
        for (i = 0; i < 50 && dma_done !== 1'b1; i++) @(negedge ref_clk);
        if (i == 50) begin
            fail_count++;
            tally_and_finish;
        end
        @(negedge ref_clk);
    endtask
    task tally_and_finish;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_wrap;
        {buffer_limit_level, wrap_enable, buffer_start_channel} = {3'h1, 1'b1, 5'h02};
        conv(5'h01, 10'h011, 0);
        `CHK(current_buffer_pointer_q, 3'h0)
        `CHK(eoc_flag_q, 1'b1)
        conv(5'h03, 10'h033, 1);
        `CHK(current_buffer_pointer_q, 3'h0)
        `CHK(result_register_q, 10'h033)
        conv(5'h02, 10'h0AA, 0);
        `CHK(current_buffer_pointer_q, 3'h1)
        conv(5'h03, 10'h0BB, 0);
        `CHK(current_buffer_pointer_q, 3'h0)
        `CHK(limit_reached_flag_q, 1'b1)
        `CHK(irq_q, 1'b0)
        conv(5'h04, 10'h0CC, 0);
        burst;
        `CHK(words[9:0], 10'h0CC)
        `CHK(words[19:10], 10'h0BB)
        `CHK(limit_reached_flag_q, 1'b0)
    endtask
    task t_stop;
        {wrap_enable, buffer_limit_level} = {1'b0, 3'h2};
        ctrl(3'h6);
        `CHK(current_buffer_pointer_q, 3'h6)
        for (int k = 0; k < 5; k++) conv(5'h02, 10'h100 + k[9:0], 0);
        `CHK(current_buffer_pointer_q, 3'h2)
        `CHK(buffering_active_q, 1'b0)
        `CHK(limit_reached_flag_q, 1'b1)
        conv(5'h02, 10'h2AA, 0);
        `CHK(result_register_q, 10'h2AA)
        `CHK(current_buffer_pointer_q, 3'h2)
        limit_reached_irq_enable = 1;
        @(negedge ref_clk);
        `CHK(irq_q, 1'b1)
        pulse(limit_flag_wr0);
        `CHK(limit_reached_flag_q, 1'b0)
        `CHK(irq_q, 1'b0)
        ctrl(3'h3);
        `CHK(buffering_active_q, 1'b1)
        conv(5'h02, 10'h133, 0);
        `CHK(current_buffer_pointer_q, 3'h4)
        burst;
        `CHK(words[69:60], 10'h100)
        `CHK(words[19:10], 10'h103)
        `CHK(words[29:20], 10'h104)
        `CHK(words[39:30], 10'h133)
    endtask
    task t_protect;
        conv(5'h00, 10'h155, 0);
        end_of_conversion_irq_enable = 1;
        @(negedge ref_clk);
        `CHK(irq_q, 1'b1)
        conv(5'h00, 10'h3C3, 0);
        `CHK(protection_pause_bit_q, 1'b1)
        `CHK(result_register_q, 10'h155)
        `CHK(conv_hold_q, 1'b1)
        pulse(eoc_flag_wr0);
        `CHK(result_register_q, 10'h3C3)
        `CHK(conv_hold_q, 1'b0)
        `CHK(protection_pause_bit_q, 1'b1)
        pulse(pause_wr0);
        `CHK(protection_pause_bit_q, 1'b0)
        end_of_conversion_irq_enable = 0;
        pulse(eoc_flag_wr0);
        `CHK(eoc_flag_q, 1'b0)
        `CHK(irq_q, 1'b0)
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        reset = 0;
        @(negedge ref_clk);
        `CHK(current_buffer_pointer_q, 3'h0)
        `CHK(buffering_active_q, 1'b1)
        t_wrap;
        t_stop;
        t_protect;
        tally_and_finish;
    end
endmodule // arb_core_tb
bind arb_core arb_core_assertions chk (.*);
`default_nettype wire
